// *** verilog/dss_defines.vh ***
// Constants for the disk servo end-of-travel and load sequencer.
`ifndef DSS_DEFINES_VH
`define DSS_DEFINES_VH

// ----------------------------------------------------------------------
// Register map, byte addresses on the APB bus
// ----------------------------------------------------------------------
`define DSS_ADDR_SEEK 12'h000
`define DSS_ADDR_CMD 12'h004
`define DSS_ADDR_STATUS 12'h008
`define DSS_ADDR_POS 12'h00c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DSS_CMD_RTZ 0
`define DSS_ST_SEEK_ERR 0
`define DSS_ST_BUSY 1
`define DSS_ST_ON_CYL 2
`define DSS_ST_SEEK_DONE 3
`define DSS_ST_READY 4
`define DSS_ST_FAULT 5
`define DSS_ST_FWD_EOT 6
`define DSS_ST_REV_EOT 7
`define DSS_ST_NO_SERVO 8
`define DSS_ST_LOAD 9

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define DSS_CYL_RESET 10'h000
`define DSS_CLK_MHZ 50
`define DSS_NO_SERVO_US 350000
`define DSS_ON_CYL_US 1750
`define DSS_NO_SERVO_CYC (`DSS_NO_SERVO_US * `DSS_CLK_MHZ)
`define DSS_ON_CYL_CYC (`DSS_ON_CYL_US * `DSS_CLK_MHZ)

`endif

// *** verilog/dss_delay_timer.v ***
// Restartable delay counter that flags when its run input has held long.
`timescale 1ns/100ps
module dss_delay_timer #(
  parameter W = 25,
  parameter [W-1:0] COUNT = 25'd100
) (
  input wire pclk,
  input wire presetn,
  input wire run,
  output reg done_r
);

  reg [W-1:0] count_r;

  // Any drop of run restarts the delay from zero.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= {W{1'b0}};
      done_r <= 1'b0;
    end else if (!run) begin
      count_r <= {W{1'b0}};
      done_r <= 1'b0;
    end else if (count_r == COUNT - 1'b1) begin
      done_r <= 1'b1; // Holds count; done stays until run drops.
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

endmodule

// *** verilog/dss_sequencer.v ***
// Servo sequencer: cylinder pulses, end of travel, head load and APB.
`timescale 1ns/100ps
`include "dss_defines.vh"
module dss_sequencer #(
  parameter CW = 10,
  parameter [24:0] NO_SERVO_CYC = `DSS_NO_SERVO_CYC,
  parameter [24:0] ON_CYL_CYC = `DSS_ON_CYL_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_r,
  output reg pready_r,
  output reg pslverr_r,
  input wire start_switch,
  input wire fault_switch,
  input wire spindle_at_speed,
  input wire servo_null_window,
  input wire integ_over_limit,
  input wire even_dibit,
  input wire odd_dibit,
  input wire dibits_present,
  input wire fine_below_limit,
  input wire fine_at_zero,
  output reg cyl_pulse_r,
  output reg integ_reset_r,
  output reg fwd_eot_enable_r,
  output reg fine_enable_r,
  output reg fine_latch_r,
  output reg slope_r,
  output reg voice_coil_power_relay_r,
  output reg load_drive_r,
  output reg retract_r,
  output reg on_cylinder_r,
  output reg seek_error_r,
  output reg ready_lamp_r,
  output reg fault_lamp_r
);

  // --------------------------------------------------------------------
  // States and locals
  // --------------------------------------------------------------------
  localparam [2:0] ST_OFF = 3'd0;
  localparam [2:0] ST_SPIN = 3'd1;
  localparam [2:0] ST_LOAD = 3'd2;
  localparam [2:0] ST_FINE = 3'd3;
  localparam [2:0] ST_READY = 3'd4;
  localparam [2:0] ST_FAULT = 3'd5;
  localparam NS = 10;

  reg [2:0] state_r;
  reg [NS-1:0] sync1_r;
  reg [NS-1:0] sync2_r;
  reg cyl_prev_r;
  reg on_cyl_prev_r;
  reg fault_sw_prev_r;
  reg [CW-1:0] ttg_r;
  reg [CW-1:0] cyl_addr_r;
  reg seek_busy_r;
  reg seek_rev_r;
  reg seek_done_r;
  reg fwd_eot_r;
  reg rev_eot_r;
  reg no_servo_r;
  reg rtz_latch_r;
  reg servo_ready_r;
  wire s_start;
  wire s_fault_sw;
  wire s_speed;
  wire s_null;
  wire s_integ;
  wire s_even;
  wire s_odd;
  wire s_dibits;
  wire s_fine_lo;
  wire s_fine_zero;
  wire cyl_event;
  wire on_cyl_rise;
  wire fault_press;
  wire no_servo_done;
  wire on_cyl_done;
  wire wr_access;
  wire wr_seek;
  wire wr_rtz;
  wire fwd_eot_hit;
  wire rev_eot_hit;
  wire [CW-1:0] target;
  wire [31:0] status_word;

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  // Panel switches and comparators are all asynchronous to pclk.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= {NS{1'b0}};
      sync2_r <= {NS{1'b0}};
    end else begin
      sync1_r <= {fine_at_zero, fine_below_limit, dibits_present, odd_dibit,
        even_dibit, integ_over_limit, servo_null_window, spindle_at_speed,
        fault_switch, start_switch};
      sync2_r <= sync1_r;
    end
  end

  assign s_start = sync2_r[0];
  assign s_fault_sw = sync2_r[1];
  assign s_speed = sync2_r[2];
  assign s_null = sync2_r[3];
  assign s_integ = sync2_r[4];
  assign s_even = sync2_r[5];
  assign s_odd = sync2_r[6];
  assign s_dibits = sync2_r[7];
  assign s_fine_lo = sync2_r[8];
  assign s_fine_zero = sync2_r[9];

  // Edge detection on synchronised levels only.
  assign cyl_event = s_null & ~cyl_prev_r;
  assign on_cyl_rise = on_cylinder_r & ~on_cyl_prev_r;
  assign fault_press = s_fault_sw & ~fault_sw_prev_r;
  assign fwd_eot_hit = fwd_eot_enable_r & s_even & seek_busy_r;
  assign rev_eot_hit = s_integ & s_odd & seek_busy_r & seek_rev_r;

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  assign wr_access = psel & penable & pready_r & pwrite;
  assign wr_seek = wr_access & (paddr == `DSS_ADDR_SEEK) & servo_ready_r;
  assign wr_rtz = wr_access & (paddr == `DSS_ADDR_CMD) &
    pwdata[`DSS_CMD_RTZ];
  assign target = pwdata[CW-1:0];
  assign status_word = {22'h000000, (state_r == ST_LOAD), no_servo_r,
    rev_eot_r, fwd_eot_r, fault_lamp_r, servo_ready_r, seek_done_r,
    on_cylinder_r, seek_busy_r, seek_error_r};

  // Read data is latched in the setup cycle so the access has no wait.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= psel & ~penable;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      if (psel & ~penable) begin
        case (paddr)
          `DSS_ADDR_SEEK: prdata_r <= {{(32-CW){1'b0}}, cyl_addr_r};
          `DSS_ADDR_CMD: prdata_r <= 32'h00000000;
          `DSS_ADDR_STATUS: prdata_r <= status_word;
          `DSS_ADDR_POS: prdata_r <= {{(32-CW){1'b0}}, ttg_r};
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Delay counters
  // --------------------------------------------------------------------
  // Dibit watchdog runs while heads should be over servo tracks.
  dss_delay_timer #(.W(25), .COUNT(NO_SERVO_CYC)) u_no_servo (
    .pclk(pclk),
    .presetn(presetn),
    .run(~s_dibits & ((state_r == ST_LOAD) | (state_r == ST_FINE) |
      (state_r == ST_READY))),
    .done_r(no_servo_done)
  );

  dss_delay_timer #(.W(25), .COUNT(ON_CYL_CYC)) u_on_cyl (
    .pclk(pclk),
    .presetn(presetn),
    .run(fine_latch_r & s_fine_lo),
    .done_r(on_cyl_done)
  );

  // --------------------------------------------------------------------
  // Servo pulse path and seek bookkeeping
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyl_prev_r <= 1'b0;
      on_cyl_prev_r <= 1'b0;
      fault_sw_prev_r <= 1'b0;
      cyl_pulse_r <= 1'b0;
      integ_reset_r <= 1'b1;
      fwd_eot_enable_r <= 1'b0;
      on_cylinder_r <= 1'b0;
      ttg_r <= `DSS_CYL_RESET;
      cyl_addr_r <= `DSS_CYL_RESET;
      seek_busy_r <= 1'b0;
      seek_rev_r <= 1'b0;
      seek_done_r <= 1'b0;
      fwd_eot_r <= 1'b0;
      seek_error_r <= 1'b0;
      slope_r <= 1'b0;
      fine_enable_r <= 1'b0;
    end else begin
      cyl_prev_r <= s_null;
      on_cyl_prev_r <= on_cylinder_r;
      fault_sw_prev_r <= s_fault_sw;
      cyl_pulse_r <= s_null;
      // Loads and retracts also hold the integrator at ground.
      integ_reset_r <= s_null | (state_r != ST_READY);
      fwd_eot_enable_r <= s_integ;
      on_cylinder_r <= on_cyl_done;
      if (cyl_event && ttg_r != {CW{1'b0}}) begin
        ttg_r <= ttg_r - 1'b1;
      end else if (on_cyl_rise && ttg_r == {{(CW-1){1'b0}}, 1'b1}) begin
        ttg_r <= {CW{1'b0}};
      end
      // After a forward end of travel fine stays on until a recalibrate.
      fine_enable_r <= (seek_busy_r & (ttg_r <= {{(CW-1){1'b0}}, 1'b1})) |
        fwd_eot_r;
      if (on_cylinder_r && ttg_r == {CW{1'b0}} && seek_busy_r) begin
        seek_done_r <= 1'b1;
        seek_busy_r <= 1'b0;
      end
      if (wr_seek) begin
        seek_busy_r <= 1'b1;
        seek_done_r <= 1'b0;
        seek_rev_r <= target < cyl_addr_r;
        ttg_r <= (target < cyl_addr_r) ? cyl_addr_r - target :
          target - cyl_addr_r;
        cyl_addr_r <= target;
        slope_r <= target[0];
      end
      if (fwd_eot_hit) begin
        // Heads sit on the inner guard; fine loop backs them off.
        fwd_eot_r <= 1'b1;
        seek_busy_r <= 1'b0;
        ttg_r <= `DSS_CYL_RESET;
        cyl_addr_r <= `DSS_CYL_RESET;
        fine_enable_r <= 1'b1;
        slope_r <= 1'b0;
      end
      if (rev_eot_hit || state_r == ST_SPIN) begin
        seek_busy_r <= 1'b0;
        ttg_r <= `DSS_CYL_RESET;
        cyl_addr_r <= `DSS_CYL_RESET;
        slope_r <= 1'b0;
      end
      // A new hit in the same cycle as the clear keeps the flag set.
      if (wr_rtz && !fwd_eot_hit) begin
        fwd_eot_r <= 1'b0;
      end
      // Set wins over the clear when both land together.
      if (fwd_eot_hit || rev_eot_hit) begin
        seek_error_r <= 1'b1;
      end else if (wr_rtz) begin
        seek_error_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Head load sequence
  // --------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_OFF;
      voice_coil_power_relay_r <= 1'b0;
      load_drive_r <= 1'b0;
      fine_latch_r <= 1'b0;
      rev_eot_r <= 1'b0;
      no_servo_r <= 1'b0;
      rtz_latch_r <= 1'b0;
      retract_r <= 1'b0;
      servo_ready_r <= 1'b0;
      ready_lamp_r <= 1'b0;
      fault_lamp_r <= 1'b0;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (s_start) begin
            state_r <= ST_SPIN;
          end
        end
        ST_SPIN: begin
          if (s_speed) begin
            voice_coil_power_relay_r <= 1'b1;
            load_drive_r <= 1'b1;
            rev_eot_r <= 1'b0;
            state_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // Fine latch stays jammed off while loading forward.
          fine_latch_r <= 1'b0;
          if (s_dibits && s_odd) begin
            load_drive_r <= 1'b0;
            rev_eot_r <= 1'b1;
            fine_latch_r <= 1'b1;
            state_r <= ST_FINE;
          end
        end
        ST_FINE: begin
          if (s_fine_zero) begin
            servo_ready_r <= 1'b1;
            ready_lamp_r <= 1'b1;
            state_r <= ST_READY;
          end
        end
        ST_READY: begin
          if (wr_seek) begin
            fine_latch_r <= 1'b0;
          end else if (fine_enable_r) begin
            fine_latch_r <= 1'b1;
          end
          if (rev_eot_hit || wr_rtz) begin
            // Outer guard or a recalibrate reloads to cylinder zero.
            rev_eot_r <= rev_eot_hit;
            servo_ready_r <= 1'b0;
            ready_lamp_r <= 1'b0;
            fine_latch_r <= 1'b0;
            load_drive_r <= 1'b1;
            state_r <= ST_LOAD;
          end
        end
        ST_FAULT: begin
          if (fault_press) begin
            fault_lamp_r <= 1'b0;
            rtz_latch_r <= 1'b0;
            retract_r <= 1'b0;
            load_drive_r <= 1'b1;
            state_r <= ST_LOAD;
          end
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
      if (no_servo_done && state_r != ST_FAULT) begin
        // Same watchdog covers first load, retries and lost tracks.
        no_servo_r <= state_r == ST_READY;
        rtz_latch_r <= 1'b1;
        retract_r <= 1'b1;
        fault_lamp_r <= 1'b1;
        load_drive_r <= 1'b0;
        fine_latch_r <= 1'b0;
        servo_ready_r <= 1'b0;
        ready_lamp_r <= 1'b0;
        state_r <= ST_FAULT;
      end
      if (!s_speed && state_r != ST_OFF) begin
        // Spindle lost speed: drop the coil and wait for a restart.
        voice_coil_power_relay_r <= 1'b0;
        servo_ready_r <= 1'b0;
        ready_lamp_r <= 1'b0;
        load_drive_r <= 1'b0;
        state_r <= ST_OFF;
      end
    end
  end

endmodule

// *** test/dss_sequencer_monitor.sv ***
// Concurrent checks on the servo sequencer ports.
`timescale 1ns/100ps
`include "dss_defines.vh"
module dss_sequencer_monitor #(
  parameter CW = 10,
  parameter [24:0] NO_SERVO_CYC = 25'h0000028,
  parameter [24:0] ON_CYL_CYC = 25'h000000a
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire spindle_at_speed,
  input wire servo_null_window,
  input wire integ_over_limit,
  input wire even_dibit,
  input wire dibits_present,
  input wire fine_below_limit,
  input wire cyl_pulse_r,
  input wire integ_reset_r,
  input wire fwd_eot_enable_r,
  input wire fine_enable_r,
  input wire slope_r,
  input wire voice_coil_power_relay_r,
  input wire retract_r,
  input wire on_cylinder_r,
  input wire seek_error_r,
  input wire fault_lamp_r
);
  // Run lengths of the two timed inputs, restarted when they drop.
  // They bound how early a delayed output may rise.
  reg [24:0] below_cnt_r;
  reg [24:0] nodib_cnt_r;
  wire rtz_wr = psel && penable && pwrite && paddr == `DSS_ADDR_CMD &&
    pwdata[`DSS_CMD_RTZ];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      below_cnt_r <= 25'h0;
      nodib_cnt_r <= 25'h0;
    end else begin
      below_cnt_r <= fine_below_limit ? below_cnt_r + 25'h1 : 25'h0;
      nodib_cnt_r <= dibits_present ? 25'h0 : nodib_cnt_r + 25'h1;
    end
  end
  // Inputs pass two sync flops, so causes are looked up three edges back.
  default clocking dcb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_relay_speed: assert property (!spindle_at_speed [*5] |->
    !voice_coil_power_relay_r) else $error("relay on without speed");
  a_cyl_cause: assert property ($rose(cyl_pulse_r) |->
    $past(servo_null_window, 3)) else $error("pulse outside window");
  a_integ_ground: assert property (cyl_pulse_r |-> integ_reset_r)
    else $error("integrator not grounded");
  a_eot_cause: assert property ($rose(fwd_eot_enable_r) |->
    $past(integ_over_limit, 3)) else $error("eot enable early");
  a_err_sticky: assert property (seek_error_r && !rtz_wr |=>
    seek_error_r) else $error("seek error lost");
  a_err_effects: assert property ($rose(seek_error_r) &&
    $past(even_dibit, 3) |-> ##[0:1] (fine_enable_r && !slope_r))
    else $error("eot effects");
  a_fault_retract: assert property ($rose(fault_lamp_r) |->
    ##[0:2] retract_r) else $error("fault without retract");
  a_on_cyl_delay: assert property ($rose(on_cylinder_r) |->
    below_cnt_r >= ON_CYL_CYC) else $error("on cylinder early");
  a_fault_delay: assert property ($rose(fault_lamp_r) |->
    nodib_cnt_r >= NO_SERVO_CYC) else $error("fault early");
endmodule
bind dss_sequencer dss_sequencer_monitor #(
  .CW(CW),
  .NO_SERVO_CYC(NO_SERVO_CYC),
  .ON_CYL_CYC(ON_CYL_CYC)
) mon_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .spindle_at_speed, .servo_null_window, .integ_over_limit, .even_dibit,
  .dibits_present, .fine_below_limit, .cyl_pulse_r, .integ_reset_r,
  .fwd_eot_enable_r, .fine_enable_r, .slope_r, .voice_coil_power_relay_r,
  .retract_r, .on_cylinder_r, .seek_error_r, .fault_lamp_r
);

// *** test/dss_ctrl_model.sv ***
// Storage controller model: APB master issuing seeks and zero returns.
`timescale 1ns/100ps
`include "dss_defines.vh"
module dss_ctrl_model (
  input wire pclk,
  input wire [31:0] prdata_r,
  input wire pready_r,
  input wire pslverr_r,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // Idle bus at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer; the wait is bounded so a dead slave cannot hang us.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er, output logic ok);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_r !== 1'b1 && n < 20);
    ok = (n < 20);
    rd = prdata_r;
    er = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
  // Only this command may clear a reported seek error.
  task return_to_track_zero(output logic ok);
    logic [31:0] rd;
    logic er;
    apb(1'b1, `DSS_ADDR_CMD, 32'h1 << `DSS_CMD_RTZ, rd, er, ok);
  endtask
endmodule

// *** test/dss_sequencer_test.sv ***
// Self-checking bench for the servo sequencer.
`timescale 1ns/100ps
`include "dss_defines.vh"
module dss_sequencer_test;
  logic pclk, presetn, start_switch, fault_switch, spindle_at_speed;
  logic servo_null_window, integ_over_limit, even_dibit, odd_dibit;
  logic dibits_present, fine_below_limit, fine_at_zero, erv, okv;
  logic [31:0] seed = 32'h00003bba;
  logic [31:0] rdv, tgt;
  wire psel, penable, pwrite, pready_r, pslverr_r, cyl_pulse_r;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata_r;
  wire integ_reset_r, fwd_eot_enable_r, fine_enable_r, fine_latch_r;
  wire slope_r, voice_coil_power_relay_r, load_drive_r, retract_r;
  wire on_cylinder_r, seek_error_r, ready_lamp_r, fault_lamp_r;
  wire [6:0] sv = {fault_lamp_r, seek_error_r, ready_lamp_r,
    on_cylinder_r, fine_latch_r, load_drive_r, voice_coil_power_relay_r};
  int err_count = 0;
  int check_count = 0;
  // Short delays keep the run brief; the checker inherits them.
  dss_sequencer #(.NO_SERVO_CYC(25'h28), .ON_CYL_CYC(25'h0a)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_r,
    .pready_r, .pslverr_r, .start_switch, .fault_switch, .spindle_at_speed,
    .servo_null_window, .integ_over_limit, .even_dibit, .odd_dibit,
    .dibits_present, .fine_below_limit, .fine_at_zero, .cyl_pulse_r,
    .integ_reset_r, .fwd_eot_enable_r, .fine_enable_r, .fine_latch_r,
    .slope_r, .voice_coil_power_relay_r, .load_drive_r, .retract_r,
    .on_cylinder_r, .seek_error_r, .ready_lamp_r, .fault_lamp_r);
  dss_ctrl_model ctl_u (.pclk, .prdata_r, .pready_r, .pslverr_r, .psel,
    .penable, .pwrite, .paddr, .pwdata);
  // Free-running system clock.
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Repeatable pseudo-random source.
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task bus(logic w, logic [11:0] a, logic [31:0] d);
    ctl_u.apb(w, a, d, rdv, erv, okv);
    chk("bus answer", 32'h1, {31'h0, okv});
    if (!okv) report_and_stop();
  endtask
  task rdchk(logic [11:0] a, logic [31:0] e, string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, e, rdv);
  endtask
  // Bounded wait for one output to reach a level.
  task wt(int id, logic v, int lim);
    int n;
    for (n = 0; n < lim && sv[id] !== v; n++) @(posedge pclk);
    chk("wait", {31'h0, v}, {31'h0, sv[id]});
    if (n >= lim) report_and_stop();
  endtask
  task pulses(int k);
    repeat (k) begin
      servo_null_window <= 1'b1;
      repeat (4) @(posedge pclk);
      servo_null_window <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  initial begin
    {presetn, start_switch, fault_switch, spindle_at_speed} = 4'h0;
    {servo_null_window, integ_over_limit, even_dibit, odd_dibit} = 4'h0;
    {dibits_present, fine_below_limit, fine_at_zero} = 3'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h010, 32'h0, "unmapped data");
    chk("slverr", 32'h1, {31'h0, erv});
    bus(1'b1, `DSS_ADDR_SEEK, 32'h5);
    rdchk(`DSS_ADDR_SEEK, 32'h0, "seek refused");
    $display("test registers done");
    start_switch <= 1'b1;
    spindle_at_speed <= 1'b1;
    wt(0, 1'b1, 50);
    wt(1, 1'b1, 50);
    dibits_present <= 1'b1;
    odd_dibit <= 1'b1;
    wt(2, 1'b1, 50);
    chk("load drive", 32'h0, {31'h0, load_drive_r});
    odd_dibit <= 1'b0;
    fine_below_limit <= 1'b1;
    wt(3, 1'b1, 100);
    fine_at_zero <= 1'b1;
    wt(4, 1'b1, 100);
    rdchk(`DSS_ADDR_STATUS, 32'h94, "load status");
    chk("rev eot", 32'h1, {31'h0, rdv[`DSS_ST_REV_EOT]});
    $display("test load done");
    tgt = (xs() >> 28) | 32'h2;
    fine_below_limit <= 1'b0;
    wt(3, 1'b0, 50);
    bus(1'b1, `DSS_ADDR_SEEK, tgt);
    rdchk(`DSS_ADDR_POS, tgt, "to go");
    pulses(tgt - 1);
    rdchk(`DSS_ADDR_POS, 32'h1, "to go");
    fine_below_limit <= 1'b1;
    wt(3, 1'b1, 100);
    repeat (3) @(posedge pclk);
    rdchk(`DSS_ADDR_POS, 32'h0, "last step");
    rdchk(`DSS_ADDR_STATUS, 32'h9c, "seek status");
    chk("seek done", 32'h1, {31'h0, rdv[`DSS_ST_SEEK_DONE]});
    $display("test seek done");
    fine_below_limit <= 1'b0;
    bus(1'b1, `DSS_ADDR_SEEK, tgt + 32'h8);
    integ_over_limit <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("no even", 32'h0, {31'h0, seek_error_r});
    even_dibit <= 1'b1;
    wt(5, 1'b1, 20);
    {integ_over_limit, even_dibit} <= 2'h0;
    rdchk(`DSS_ADDR_POS, 32'h0, "eot to go");
    rdchk(`DSS_ADDR_SEEK, 32'h0, "eot cyl");
    chk("fine en", 32'h1, {31'h0, fine_enable_r});
    chk("slope", 32'h0, {31'h0, slope_r});
    repeat (10) @(posedge pclk);
    chk("held", 32'h1, {31'h0, seek_error_r});
    ctl_u.return_to_track_zero(okv);
    chk("rtz answer", 32'h1, {31'h0, okv});
    repeat (2) @(posedge pclk);
    chk("cleared", 32'h0, {31'h0, seek_error_r});
    $display("test eot done");
    dibits_present <= 1'b0;
    wt(6, 1'b1, 300);
    chk("retract", 32'h1, {31'h0, retract_r});
    dibits_present <= 1'b1;
    fault_switch <= 1'b1;
    repeat (4) @(posedge pclk);
    fault_switch <= 1'b0;
    wt(6, 1'b0, 50);
    $display("test fault done");
    odd_dibit <= 1'b1;
    wt(4, 1'b1, 100);
    odd_dibit <= 1'b0;
    bus(1'b1, `DSS_ADDR_SEEK, 32'h5);
    bus(1'b1, `DSS_ADDR_SEEK, 32'h2);
    {integ_over_limit, odd_dibit} <= 2'h3;
    wt(5, 1'b1, 20);
    {integ_over_limit, odd_dibit} <= 2'h0;
    rdchk(`DSS_ADDR_SEEK, 32'h0, "rev cyl");
    wt(4, 1'b1, 100);
    rdchk(`DSS_ADDR_STATUS, 32'h91, "rev status");
    $display("test reverse eot done");
    dibits_present <= 1'b0;
    wt(6, 1'b1, 300);
    rdchk(`DSS_ADDR_STATUS, 32'h1a1, "no servo status");
    $display("test lost tracks done");
    report_and_stop();
  end
endmodule
